// file: hw/csr_params.svh
// Purpose: offsets, field positions, reset values for the camera csr slice
// Assumes: byte addresses on a 32-bit axi4-lite bus
// Notes: definitions only
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define SWTRIG_OFFSET 12'h62c
`define DEPTH_OFFSET 12'h630
`define BRIGHT_OFFSET 12'h800
`define BR_PRESENCE_BIT 0
`define BR_ABS_BIT 1
`define BR_ONE_PUSH_BIT 5
`define BR_ON_OFF_BIT 6
`define BR_AUTO_BIT 7
`define BR_VALUE_LSB 20
`define BR_VALUE_RST 12'h000
`define DEPTH_8 8'h08
`define DEPTH_12 8'h0c
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// file: hw/csr_pkg.sv
// Purpose: shared types for the camera csr slice
// Assumes: nothing
// Notes: coding selects the depth reported
package csr_pkg;
  typedef enum logic [1:0] {
    coding_mono8 = 2'h0,
    coding_mono12 = 2'h1,
    coding_raw12 = 2'h2,
    coding_color8 = 2'h3
  } coding_t;
  typedef struct packed {
    logic present;
    logic abs_ctrl;
    logic one_push;
    logic on_off;
    logic auto_mode;
    logic [11:0] value;
  } bright_t;
endpackage

// file: hw/depth_decode.sv
// Purpose: registered bit depth from the current coding
// Assumes: coding input is from same clock
// Notes: colour reports bits per component
`timescale 1ns/1ps
`include "csr_params.svh"
module depth_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire csr_pkg::coding_t coding,
  output logic [7:0] depth
);
  // registered so the read path sees a stable value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth <= `DEPTH_8;
    end else begin
      case (coding)
        csr_pkg::coding_mono12: depth <= `DEPTH_12;
        csr_pkg::coding_raw12: depth <= `DEPTH_12;
        default: depth <= `DEPTH_8;
      endcase
    end
  end
endmodule

// file: hw/camera_trigger_depth_brightness_csr.sv
// Purpose: axi4-lite slave for trigger, data depth and brightness registers
// Assumes: single clock, synchronous active-low reset, status inputs on aclk
// Notes: one write and one read handled at a time
`timescale 1ns/1ps
`include "csr_params.svh"
// Functional notes
// - in software trigger source, writing 1 sets trigger, 0 resets it.
// - in trigger mode 0 the trigger bit clears itself after being set.
// - depth register low byte reports effective bit depth of image data.
// - depth is 8 or 12 per pixel, or 8 per colour component.
// - read-only presence bit reads 1 when brightness control exists.
// - absolute bit 1 ignores value field; 0 uses value field.
// - absolute-control bit is read-only; writes have no effect.
// - one-push bit read-only, shows running operation, ignored in automatic mode.
// - read-only on/off bit; while off all other fields read-only.
// - read-only auto/manual bit reads 0 manual, 1 automatic.
module camera_trigger_depth_brightness_csr #(
  parameter logic PRESENT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_src_software,
  input wire logic trig_mode_zero,
  input wire csr_pkg::coding_t coding,
  input wire logic bright_on,
  input wire logic bright_auto,
  input wire logic one_push_busy,
  output logic sw_trigger,
  output logic [11:0] brightness,
  output logic brightness_valid
);
  typedef enum logic [2:0] {
    wr_idle = 3'b001,
    wr_exec = 3'b010,
    wr_resp = 3'b100
  } wr_state_t;
  wr_state_t wr_state_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic trig_reg;
  logic [11:0] value_reg;
  logic [7:0] depth;
  logic auto_reg;
  logic on_reg;
  logic push_reg;
  csr_pkg::bright_t bright;

  // word-aligned decode used by both channels
  function automatic logic [1:0] decode(input logic [11:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if ({addr[11:2], 2'h0} == `SWTRIG_OFFSET) begin
      sel = 2'h1;
    end else if ({addr[11:2], 2'h0} == `DEPTH_OFFSET) begin
      sel = 2'h2;
    end else if ({addr[11:2], 2'h0} == `BRIGHT_OFFSET) begin
      sel = 2'h3;
    end
    return sel;
  endfunction

  depth_decode u_depth (
    .aclk(aclk),
    .aresetn(aresetn),
    .coding(coding),
    .depth(depth)
  );

  // status inputs registered so reads and outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_reg <= 1'b0;
      on_reg <= 1'b0;
      push_reg <= 1'b0;
    end else begin
      auto_reg <= bright_auto;
      on_reg <= bright_on;
      push_reg <= one_push_busy & ~bright_auto;
    end
  end

  // abs bit is tied low since no absolute_setting_register exists
  always_comb begin
    bright.present = PRESENT;
    bright.abs_ctrl = 1'b0;
    bright.one_push = push_reg;
    bright.on_off = on_reg;
    bright.auto_mode = auto_reg;
    bright.value = value_reg;
  end

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_state_reg == wr_exec) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_state_reg == wr_exec) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // ready only while idle and that half not yet taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= (wr_state_reg == wr_idle) && !aw_held_reg
                       && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= (wr_state_reg == wr_idle) && !w_held_reg
                      && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // write sequencer: execute once both halves held, then respond
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= wr_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      case (wr_state_reg)
        wr_idle: begin
          if (aw_held_reg && w_held_reg) begin
            wr_state_reg <= wr_exec;
          end
        end
        wr_exec: begin
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= (decode(awaddr_reg) == 2'h0) ? `AXI_SLVERR : `AXI_OKAY;
          wr_state_reg <= wr_resp;
        end
        wr_resp: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= wr_idle;
          end
        end
        default: wr_state_reg <= wr_idle;
      endcase
    end
  end

  // software trigger bit; self clear beats nothing since a set lasts a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_reg <= 1'b0;
    end else if (wr_state_reg == wr_exec && decode(awaddr_reg) == 2'h1
                 && wstrb_reg[0] && trig_src_software) begin
      trig_reg <= wdata_reg[0];
    end else if (trig_mode_zero && trig_reg) begin
      trig_reg <= 1'b0;
    end
  end

  // value field writable only while control is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_reg <= `BR_VALUE_RST;
    end else if (wr_state_reg == wr_exec && decode(awaddr_reg) == 2'h3 && on_reg) begin
      if (wstrb_reg[2]) begin
        value_reg[3:0] <= wdata_reg[`BR_VALUE_LSB+3:`BR_VALUE_LSB];
      end
      if (wstrb_reg[3]) begin
        value_reg[11:4] <= wdata_reg[31:24];
      end
    end
  end

  // outputs to the trigger logic and image pipeline
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_trigger <= 1'b0;
      brightness <= `BR_VALUE_RST;
      brightness_valid <= 1'b0;
    end else begin
      sw_trigger <= trig_reg;
      brightness <= value_reg;
      // abs control is always 0 here, so the value field is in charge
      brightness_valid <= PRESENT & on_reg & ~auto_reg & ~bright.abs_ctrl;
    end
  end

  // read channel: one read at a time, answer one cycle after taking it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        case (decode(s_axi_araddr))
          2'h1: s_axi_rdata <= {31'h0000_0000, trig_reg};
          2'h2: s_axi_rdata <= {24'h00_0000, depth};
          2'h3: begin
            s_axi_rdata <= {bright.value, 12'h000, bright.auto_mode, bright.on_off,
                            bright.one_push, 3'h0, bright.abs_ctrl, bright.present};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: sim/csr_props.sv
// Purpose: port checks for the camera csr slice
// Assumes: status pins steady around reads
// Notes: status bits read two edges late
`timescale 1ns/1ps
`include "csr_params.svh"
module csr_props #(
  parameter logic PRESENT = 1'h1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic trig_src_software,
  input wire logic trig_mode_zero,
  input wire logic bright_on,
  input wire logic bright_auto,
  input wire logic one_push_busy,
  input wire logic sw_trigger,
  input wire logic [11:0] brightness,
  input wire logic brightness_valid
);
  logic [11:0] ra;
  logic br;
  // address of the read being answered
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  // answer to a feature word read
  assign br = s_axi_rvalid && ra == `BRIGHT_OFFSET;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_gate;
    !trig_src_software [*2] ##0 !sw_trigger |=> !sw_trigger;
  endproperty
  a_gate: assert property (p_gate) else $error("trigger moved");
  property p_clr;
    $rose(sw_trigger) && trig_mode_zero |=> !sw_trigger;
  endproperty
  a_clr: assert property (p_clr) else $error("no self clear");
  property p_pres;
    $rose(s_axi_rvalid) && br |-> s_axi_rdata[0] == PRESENT;
  endproperty
  a_pres: assert property (p_pres) else $error("presence bit");
  property p_abs;
    $rose(s_axi_rvalid) && br |-> !s_axi_rdata[1];
  endproperty
  a_abs: assert property (p_abs) else $error("abs bit set");
  property p_push;
    $rose(s_axi_rvalid) && br |-> s_axi_rdata[5] == $past(one_push_busy && !bright_auto, 2);
  endproperty
  a_push: assert property (p_push) else $error("one push bit");
  property p_mode;
    $rose(s_axi_rvalid) && br |-> s_axi_rdata[7:6] == $past({bright_auto, bright_on}, 2);
  endproperty
  a_mode: assert property (p_mode) else $error("on or auto bit");
  property p_off;
    !bright_on [*4] |=> $stable(brightness);
  endproperty
  a_off: assert property (p_off) else $error("value moved while off");
  property p_nv;
    (!bright_on || bright_auto) [*3] |-> !brightness_valid;
  endproperty
  a_nv: assert property (p_nv) else $error("value used wrongly");
endmodule
bind camera_trigger_depth_brightness_csr csr_props #(.PRESENT(PRESENT)) csr_props_inst (.*);

// file: sim/camera_trigger_depth_brightness_csr_tb.sv
// Purpose: bench for the camera csr slice
// Assumes: bready and rready held high
// Notes: read table, then trigger, value and reset tests
`timescale 1ns/1ps
`include "csr_params.svh"
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module camera_trigger_depth_brightness_csr_tb;
  typedef struct packed {
    logic [1:0] c;
    logic [2:0] s;
    logic [11:0] a;
    logic [7:0] e;
    logic [1:0] r;
  } row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, trig_src_software, trig_mode_zero, bright_on, bright_auto;
  logic one_push_busy, sw_trigger, brightness_valid;
  logic [11:0] s_axi_awaddr, s_axi_araddr, brightness;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  csr_pkg::coding_t coding;
  int err_total, checks, hi, h0;
  // coding, {on, auto, busy}, address, low byte, response
  row_t rows[8] = '{
    {2'h0, 3'h0, `DEPTH_OFFSET, `DEPTH_8, `AXI_OKAY},
    {2'h1, 3'h0, `DEPTH_OFFSET, `DEPTH_12, `AXI_OKAY},
    {2'h2, 3'h0, `DEPTH_OFFSET, `DEPTH_12, `AXI_OKAY},
    {2'h3, 3'h0, `DEPTH_OFFSET, `DEPTH_8, `AXI_OKAY},
    {2'h0, 3'h5, `BRIGHT_OFFSET, 8'h61, `AXI_OKAY},
    {2'h0, 3'h7, `BRIGHT_OFFSET, 8'hc1, `AXI_OKAY},
    {2'h0, 3'h1, `BRIGHT_OFFSET, 8'h21, `AXI_OKAY},
    {2'h0, 3'h4, 12'h100, 8'h00, `AXI_SLVERR}};
  camera_trigger_depth_brightness_csr #(.PRESENT(1'h1))
    camera_trigger_depth_brightness_csr_inst (.*);
  // free running bus clock
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end
  // counts high cycles so a one-cycle pulse cannot slip by
  always @(posedge aclk) hi <= hi + sw_trigger;
  // a hang ends the run as a failure
  initial begin
    repeat (3000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {trig_src_software, trig_mode_zero, bright_on, bright_auto, one_push_busy} = 5'h10;
    coding = csr_pkg::coding_mono8;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      coding <= csr_pkg::coding_t'(rows[i].c);
      {bright_on, bright_auto, one_push_busy} <= rows[i].s;
      repeat (3) @(posedge aclk);
      rd(rows[i].a);
      `CK("rdata", rows[i].e, d[7:0])
      `CK("rresp", rows[i].r, r)
    end
    $display("table done");
    wr(`SWTRIG_OFFSET, 32'h1, 4'h1);
    repeat (2) @(posedge aclk);
    `CK("trig set", 1'h1, sw_trigger)
    wr(`SWTRIG_OFFSET, 32'h0, 4'h1);
    repeat (2) @(posedge aclk);
    `CK("trig reset", 1'h0, sw_trigger)
    trig_src_software <= 1'h0;
    wr(`SWTRIG_OFFSET, 32'h1, 4'h1);
    repeat (2) @(posedge aclk);
    `CK("trig gated", 1'h0, sw_trigger)
    {trig_src_software, trig_mode_zero} <= 2'h3;
    h0 = hi;
    wr(`SWTRIG_OFFSET, 32'h1, 4'h1);
    repeat (3) @(posedge aclk);
    `CK("trig pulse", 1, hi - h0)
    $display("trigger test done");
    wr(`BRIGHT_OFFSET, 32'habc000ff, 4'hf);
    repeat (2) @(posedge aclk);
    `CK("value", 12'habc, brightness)
    `CK("in use", 1'h1, brightness_valid)
    rd(`BRIGHT_OFFSET);
    `CK("word", 32'habc00041, d)
    wr(`BRIGHT_OFFSET, 32'h00500000, 4'h4);
    repeat (2) @(posedge aclk);
    `CK("strobe", 12'hab5, brightness)
    bright_on <= 1'h0;
    repeat (3) @(posedge aclk);
    wr(`BRIGHT_OFFSET, 32'h12300000, 4'hf);
    repeat (2) @(posedge aclk);
    `CK("off value", 12'hab5, brightness)
    `CK("off use", 1'h0, brightness_valid)
    wr(12'h100, 32'hffffffff, 4'hf);
    `CK("unmapped", `AXI_SLVERR, r)
    $display("value test done");
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    `CK("rst value", `BR_VALUE_RST, brightness)
    `CK("rst trig", 1'h0, sw_trigger)
    $display("reset test done");
    end_of_test();
  end
endmodule
